// File: hdl/sprs_regs.svh
// constants for the sensor power/reset sequencer
// assumes inclusion by bare name from the package and the design module
`ifndef SPRS_REGS_SVH
`define SPRS_REGS_SVH
// pixel bus width
`define SPRS_PIX_W 12
// initialization length, in input clock cycles
`define SPRS_INIT_CYCLES 150000
// init counter width
`define SPRS_CNT_W 18
// position of the streaming bit in the control word
`define SPRS_STREAM_BIT 2
// reset value of the streaming bit
`define SPRS_STREAM_RST 1'h0
`endif

// File: hdl/sprs_pkg.sv
// types of the sensor power/reset sequencer
// assumes sprs_regs.svh is on the include path
`include "sprs_regs.svh"
package sprs_pkg;
    typedef enum logic [1:0] {
        SPRS_INIT = 2'b00,
        SPRS_STANDBY = 2'b01,
        SPRS_STREAM = 2'b10,
        SPRS_STOPPING = 2'b11
    } sprs_state_t;

    typedef struct packed {
        sprs_state_t state;
        logic [`SPRS_CNT_W-1:0] cnt;
        logic stream_bit;
        logic [`SPRS_PIX_W-1:0] pix;
    } sprs_regs_t;

    typedef struct packed {
        logic wr;
        logic [15:0] wdata;
    } sprs_ctrl_wr_t;

    typedef struct packed {
        logic row_end;
        logic frame_end;
        logic [`SPRS_PIX_W-1:0] data;
    } sprs_pix_in_t;
endpackage : sprs_pkg

// File: hdl/sprs_sequencer.sv
// sensor-side reset, initialization and standby/streaming sequencer
// assumes clk_sys is the sensor input clock and rstn is the sensor reset pin
// assumes the host keeps rails, clock and reset in the documented order
`include "sprs_regs.svh"

// Function
// - pixel outputs stay high-impedance while reset is asserted
// - after reset, 150000 input clocks of init, then software standby
// - writing one to the streaming bit leaves standby and starts output
// - clearing the bit finishes current row or frame, then soft standby
module sprs_sequencer
    import sprs_pkg::*;
#(
    parameter int INIT_CYCLES = `SPRS_INIT_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // control register write port
    input wire sprs_ctrl_wr_t ctrl_wr,
    input wire logic stop_on_frame,
    // readout side
    input wire sprs_pix_in_t pix_in,
    // status
    output logic init_done,
    output logic stream_bit,
    output logic streaming,
    // pixel pins
    output logic [`SPRS_PIX_W-1:0] pix_out,
    output logic pix_oe
);
    sprs_regs_t r;
    sprs_regs_t next_r;
    logic boundary;

    // stream and stopping both keep the pixel pins driven
    function automatic logic is_active(input sprs_state_t s);
        return (s == SPRS_STREAM) || (s == SPRS_STOPPING);
    endfunction : is_active

    // row or frame end, whichever the stop mode waits for
    function automatic logic pick_boundary(input logic on_frame, input sprs_pix_in_t p);
        return on_frame ? p.frame_end : p.row_end;
    endfunction : pick_boundary

    always_comb begin
        boundary = pick_boundary(stop_on_frame, pix_in);
    end

    always_comb begin
        next_r = r;
        // control writes are ignored until init completes
        if (ctrl_wr.wr && r.state != SPRS_INIT) begin
            next_r.stream_bit = ctrl_wr.wdata[`SPRS_STREAM_BIT];
        end
        case (r.state)
            SPRS_INIT: begin
                next_r.stream_bit = `SPRS_STREAM_RST;
                if (r.cnt == `SPRS_CNT_W'(INIT_CYCLES - 1)) begin
                    next_r.state = SPRS_STANDBY;
                end else begin
                    next_r.cnt = r.cnt + `SPRS_CNT_W'(1);
                end
            end
            SPRS_STANDBY: begin
                if (r.stream_bit) begin
                    next_r.state = SPRS_STREAM;
                end
            end
            SPRS_STREAM: begin
                if (!r.stream_bit) begin
                    next_r.state = boundary ? SPRS_STANDBY : SPRS_STOPPING;
                end
            end
            SPRS_STOPPING: begin
                if (boundary) begin
                    next_r.state = SPRS_STANDBY;
                end
            end
            default: begin
                next_r.state = SPRS_INIT;
            end
        endcase
        if (is_active(r.state)) begin
            next_r.pix = pix_in.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        init_done = (r.state != SPRS_INIT);
        stream_bit = r.stream_bit;
        streaming = is_active(r.state);
        pix_oe = rstn && streaming;
        pix_out = r.pix;
    end

    // helper: cycles since reset release, saturating
    logic [`SPRS_CNT_W:0] since_rst;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            since_rst <= '0;
        end else if (!since_rst[`SPRS_CNT_W]) begin
            since_rst <= since_rst + (`SPRS_CNT_W+1)'(1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_oe_off_init: assert property (!init_done |-> !pix_oe)
        else $error("pixel pins driven during init");
    a_init_length: assert property ($rose(init_done) |->
        since_rst == (`SPRS_CNT_W+1)'(INIT_CYCLES))
        else $error("init length wrong");
    a_bit_zero_init: assert property ($rose(init_done) |-> !stream_bit)
        else $error("stream bit set after init");
    a_standby_hold: assert property (init_done && !stream_bit && !streaming |=>
        !streaming)
        else $error("left standby without stream bit");
    a_start_stream: assert property (init_done && !streaming && stream_bit && !ctrl_wr.wr
        |=> streaming ##1 pix_oe)
        else $error("streaming did not start");
    a_stop_boundary: assert property (streaming && !stream_bit && boundary
        |=> !streaming)
        else $error("no standby at boundary");
    a_stop_finish: assert property (streaming && !stream_bit && !boundary
        |=> streaming)
        else $error("stopped mid row or frame");
    a_write_in_init: assert property (!init_done && ctrl_wr.wr |=> !stream_bit)
        else $error("write taken during init");

    // pixel path
    a_pix_capture: assert property (streaming |=> pix_out == $past(pix_in.data))
        else $error("pixel word not captured");
    a_pix_hold: assert property (!streaming |=> $stable(pix_out))
        else $error("pixel word moved in standby");
    a_oe_needs_init: assert property (pix_oe |-> init_done && streaming)
        else $error("pixel pins driven outside streaming");
    a_stop_drives: assert property (streaming && !stream_bit |-> pix_oe)
        else $error("pins released before boundary");
    a_standby_oe_off: assert property (init_done && !streaming |-> !pix_oe)
        else $error("pixel pins driven in standby");

    // stop mode decode
    a_stop_at_row: assert property (!stop_on_frame && streaming && !stream_bit
        && pix_in.row_end |=> !streaming)
        else $error("no standby at row end");
    a_stop_at_frame: assert property (stop_on_frame && streaming && !stream_bit
        && pix_in.frame_end |=> !streaming)
        else $error("no standby at frame end");
    a_frame_waits: assert property (stop_on_frame && streaming && !stream_bit
        && !pix_in.frame_end |=> streaming)
        else $error("frame mode stopped early");

    // control bit
    a_write_taken: assert property (init_done && ctrl_wr.wr |=>
        stream_bit == $past(ctrl_wr.wdata[`SPRS_STREAM_BIT]))
        else $error("control write lost");
    a_bit_hold: assert property (!ctrl_wr.wr |=> $stable(stream_bit))
        else $error("stream bit changed without write");

    // init count
    a_no_early_done: assert property (since_rst < (`SPRS_CNT_W+1)'(INIT_CYCLES)
        |-> !init_done)
        else $error("init ended early");
    a_done_sticky: assert property (init_done |=> init_done)
        else $error("init done fell");
    a_quiet_init: assert property (!init_done |-> !streaming && !stream_bit)
        else $error("active during init");

    c_init_done: cover property ($rose(init_done));
    c_stream_on: cover property ($rose(streaming));
    c_stop_frame: cover property (stop_on_frame && streaming ##1 !streaming);
    c_stop_row: cover property (!stop_on_frame && streaming ##1 !streaming);
    c_stop_wait: cover property (streaming && !stream_bit && !boundary);
endmodule : sprs_sequencer

// File: verification/sprs_readout_model.sv
// readout model: pixel words with row and frame boundary pulses
// assumes a free-running sensor input clock and active-low reset
module sprs_readout_model
    import sprs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // readout side
    output sprs_pix_in_t pix_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] col;
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) col <= 4'h0;
        else col <= col + 4'h1;
    end
    // four pixels per row, four rows per frame, data changes every cycle
    assign pix_in = '{row_end: col[1:0] == 2'h3, frame_end: col == 4'hf, data: {3{col}}};
endmodule : sprs_readout_model

// File: verification/sprs_sequencer_bench.sv
// bench for the sequencer: reset, init count, stream start and stop
// assumes the design, package and readout model are compiled first
module sprs_sequencer_bench;
    import sprs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT = 20;
    localparam int PLL_LOCK = 20;
    logic [4:0] rails = 5'h0; // pll, analog/pixel, io, core, serial
    logic clk_run = 1'b0;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic stop_on_frame = 1'b0;
    sprs_ctrl_wr_t ctrl_wr = '0;
    sprs_pix_in_t pix_in;
    logic init_done, stream_bit, streaming, pix_oe, prev_b;
    logic [11:0] pix_out, prev_data;
    int mismatches = 0;
    int n_compared = 0;
    int seed = 32'h35da;
    always #25 if (clk_run) clk_sys = ~clk_sys;
    sprs_sequencer #(.INIT_CYCLES(INIT)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
        .ctrl_wr(ctrl_wr), .stop_on_frame(stop_on_frame), .pix_in(pix_in),
        .init_done(init_done), .stream_bit(stream_bit), .streaming(streaming),
        .pix_out(pix_out), .pix_oe(pix_oe));
    sprs_readout_model i_src (.clk_sys(clk_sys), .rstn(rstn), .pix_in(pix_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // one-cycle write, random filler around the streaming bit
    task automatic wr(input logic b);
        @(posedge clk_sys) #5;
        ctrl_wr.wdata = 16'($random(seed));
        ctrl_wr.wdata[2] = b;
        ctrl_wr.wr = 1'b1;
        @(posedge clk_sys) #5;
        ctrl_wr.wr = 1'b0;
    endtask : wr
    task automatic start;
        wr(1'b1);
        chk(16'(stream_bit), 16'h1);
        @(posedge clk_sys) #5;
        chk(16'({streaming, pix_oe}), 16'h3);
        repeat (3) begin
            @(negedge clk_sys) prev_data = pix_in.data;
            @(negedge clk_sys) chk(16'(pix_out), 16'(prev_data));
        end
        $display("start done");
    endtask : start
    task automatic stop(input logic f);
        stop_on_frame = f;
        wr(1'b0);
        prev_b = 1'b0;
        repeat (40) begin
            @(negedge clk_sys);
            if (streaming !== 1'b1) break;
            prev_b = f ? pix_in.frame_end : pix_in.row_end;
        end
        chk(16'({pix_oe, streaming, prev_b}), 16'h1);
        $display("stop done, frame mode %0d", f);
    endtask : stop
    initial begin
        for (int i = 0; i < 5; i++) begin
            #100 rails[i] = 1'b1;
        end
        chk(16'(rails), 16'h1f);
        #100 clk_run = 1'b1;
        repeat (12) @(posedge clk_sys);
        chk(16'({init_done, stream_bit, streaming, pix_oe}), 16'h0);
        #5 rstn = 1'b1;
        wr(1'b1);
        repeat (INIT - 3) @(posedge clk_sys);
        #5 chk(16'({init_done, stream_bit}), 16'h0);
        @(posedge clk_sys) #5;
        chk(16'({init_done, stream_bit, streaming}), 16'h4);
        $display("init done");
        repeat (PLL_LOCK) @(posedge clk_sys);
        stop_on_frame = 1'b0;
        start();
        stop(1'b0);
        start();
        stop(1'b1);
        repeat (4) begin
            start();
            stop(1'($random(seed)));
        end
        start();
        @(posedge clk_sys) #5 rstn = 1'b0;
        #1 chk(16'({pix_oe, streaming, stream_bit}), 16'h0);
        for (int i = 4; i >= 0; i--) begin
            #100 rails[i] = 1'b0;
        end
        #1000 chk(16'({rails, pix_oe}), 16'h0);
        give_verdict();
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule : sprs_sequencer_bench
